// *** msp_board_model.sv ***
// Board side of the controller: the two mode strap pins.
// Assumes the bench picks a strap code and keeps it while reset is released.
`timescale 1ns/1ns
`default_nettype none

module msp_board_model
(
  input wire logic [1:0] strap_code,
  output wire logic mode_strap_high,
  output wire logic mode_strap_low
);
  // --------------------------------------------------------------------
  // Strap levels
  // --------------------------------------------------------------------
  // Straps are static resistors, so they are plain levels with no timing.
  // The levels only move when the bench picks a new code, so they stay put
  // across every reset release as the board must guarantee.
  assign mode_strap_high = strap_code[1];
  assign mode_strap_low = strap_code[0];
endmodule : msp_board_model

`default_nettype wire

// *** msp_defs.svh ***
// Constants of the mode strap and power state controller.
// Assumes a single 20 MHz clock; included by bare name wherever needed.
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH

// ----------------------------------------------------------------------
// Strap codes, high strap in bit 1, low strap in bit 0
// ----------------------------------------------------------------------
`define MSP_STRAP_DEBUG 2'h1
`define MSP_STRAP_PROG 2'h2
`define MSP_STRAP_NORMAL 2'h3
`define MSP_STRAP_RESERVED 2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MSP_CLK_KHZ 20000
`define MSP_INIT_TIME_US 5000
`define MSP_INIT_CYCLES ((`MSP_INIT_TIME_US * `MSP_CLK_KHZ) / 1000)
`define MSP_STRAP_HOLD_MS 256

`endif

// *** msp_mode_latch.sv ***
// Strap capture for the operating mode.
// Assumes rst_n is the power-on or brown-out reset, synchronous, active low.
`timescale 1ns/1ns
`default_nettype none

module msp_mode_latch
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mode_strap_high,
  input wire logic mode_strap_low,
  output var msp_pkg::msp_mode_t mode,
  output logic mode_valid
);
  import msp_pkg::*;

  logic armed;

  // ----------------------------------------------------------------------
  // Capture once, on the first edge after reset release
  // ----------------------------------------------------------------------
  // The straps are caught by a clocked process after release, never by the
  // reset itself, so reset only ever loads constants.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      armed <= 1'b1;
      mode_valid <= 1'b0;
      mode <= MSP_MODE_RESERVED;
    end
    else if (armed)
    begin
      armed <= 1'b0;
      mode_valid <= 1'b1;
      mode <= msp_mode_t'({mode_strap_high, mode_strap_low});
    end
  end

  // Other resets never reach this module, so the mode survives them.
  property p_mode_hold;
    @(posedge mclk) disable iff (!rst_n)
    mode_valid && $past(mode_valid) |-> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("Captured mode changed without power-on reset.");

endmodule : msp_mode_latch

`default_nettype wire

// *** msp_pkg.sv ***
// Types shared by the mode strap and power state controller.
// Assumes msp_defs.svh is on the include path.
`default_nettype none

`include "msp_defs.svh"

package msp_pkg;

  // ----------------------------------------------------------------------
  // Operating modes picked by the straps
  // ----------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MSP_MODE_RESERVED = `MSP_STRAP_RESERVED,
    MSP_MODE_DEBUG = `MSP_STRAP_DEBUG,
    MSP_MODE_PROG = `MSP_STRAP_PROG,
    MSP_MODE_NORMAL = `MSP_STRAP_NORMAL
  } msp_mode_t;

  // ----------------------------------------------------------------------
  // Device states, Gray coded along init, run, idle, power down, shutdown
  // ----------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    MSP_ST_INIT = 3'h0,
    MSP_ST_RUN = 3'h1,
    MSP_ST_IDLE = 3'h3,
    MSP_ST_PDOWN = 3'h2,
    MSP_ST_SHUT = 3'h6
  } msp_state_t;

endpackage : msp_pkg

`default_nettype wire

// *** msp_power_ctrl.sv ***
// Power state and operating mode controller, top level.
// Assumes straps, firmware requests and hardware events are synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none

`include "msp_defs.svh"

module msp_power_ctrl
#(
  parameter int INIT_CYCLES = `MSP_INIT_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mode_strap_high,
  input wire logic mode_strap_low,
  input wire logic req_idle,
  input wire logic req_pdown,
  input wire logic req_shutdown,
  input wire logic irq_pending,
  input wire logic wake_event,
  input wire logic wdt_reset,
  input wire logic sw_reset,
  input wire logic over_temperature_detector,
  input wire logic otd_select,
  input wire logic lf_pdown_select,
  output var msp_pkg::msp_mode_t mode,
  output logic mode_valid,
  output var msp_pkg::msp_state_t state,
  output logic cpu_clk_en,
  output logic core_supply_en,
  output logic lbm_active,
  output logic retention_ram_active,
  output logic otd_en,
  output logic lf_en,
  output logic always_on_en,
  output logic reinit_req
);
  import msp_pkg::*;

  localparam int CW = $clog2(INIT_CYCLES + 1);

  msp_mode_t cap_mode;
  logic cap_valid;
  msp_state_t next_state;
  logic [CW-1:0] init_cnt;
  logic cool_seen;

  // ----------------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------------
  msp_mode_latch u_mode
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .mode_strap_high(mode_strap_high),
    .mode_strap_low(mode_strap_low),
    .mode(cap_mode),
    .mode_valid(cap_valid)
  );

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  // Only power-on reset recaptures the mode; the device relies on the board
  // keeping the straps steady across that edge.
  wire is_normal = cap_valid && (cap_mode == MSP_MODE_NORMAL);
  wire is_reserved = cap_valid && (cap_mode == MSP_MODE_RESERVED);
  wire init_done = (init_cnt == CW'(INIT_CYCLES - 1)) && cap_valid && !is_reserved;
  // A hot device ignores the timer reset until it has cooled once.
  wire reset_take = (state == MSP_ST_SHUT) ? (wdt_reset && cool_seen) :
                    (wdt_reset || sw_reset);
  wire run_req = (state == MSP_ST_RUN) && is_normal;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Shutdown has the highest request priority since it protects the part.
  always_comb
  begin
    next_state = state;
    case (state)
      MSP_ST_INIT:
      begin
        if (init_done)
          next_state = MSP_ST_RUN;
      end
      MSP_ST_RUN:
      begin
        if (run_req && req_shutdown)
          next_state = MSP_ST_SHUT;
        else if (run_req && req_pdown)
          next_state = MSP_ST_PDOWN;
        else if (run_req && req_idle)
          next_state = MSP_ST_IDLE;
      end
      MSP_ST_IDLE:
      begin
        if (irq_pending)
          next_state = MSP_ST_RUN;
      end
      MSP_ST_PDOWN:
      begin
        if (wake_event)
          next_state = MSP_ST_INIT;
      end
      MSP_ST_SHUT:
      begin
        next_state = MSP_ST_SHUT;
      end
      default:
      begin
        next_state = MSP_ST_INIT;
      end
    endcase
    if (reset_take)
      next_state = MSP_ST_INIT;
  end

  // ----------------------------------------------------------------------
  // Output decodes from the next state
  // ----------------------------------------------------------------------
  // Outputs are registered from these so each one leaves a flip-flop and
  // still lines up with the state register.
  wire nx_low = (next_state == MSP_ST_PDOWN) || (next_state == MSP_ST_SHUT);
  wire nx_active = (next_state == MSP_ST_RUN) || (next_state == MSP_ST_IDLE);
  wire next_core = !nx_low;
  wire next_cpu = (next_state == MSP_ST_RUN) || (next_state == MSP_ST_INIT);
  wire next_otd = nx_active && otd_select;
  wire next_lf = nx_low ? lf_pdown_select : 1'b1;
  // Usable only when supplied; supply itself stays on.
  wire next_keep = !nx_low;
  wire next_reinit = ((state == MSP_ST_PDOWN) || (state == MSP_ST_SHUT)) ?
                     (next_state == MSP_ST_INIT) :
                     (reinit_req && (next_state == MSP_ST_INIT));

  // ----------------------------------------------------------------------
  // State and init counter
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= MSP_ST_INIT;
      init_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      init_cnt <= (next_state != MSP_ST_INIT || state != MSP_ST_INIT) ? '0 :
                  (init_done ? init_cnt : init_cnt + CW'(1));
    end
  end

  // ----------------------------------------------------------------------
  // Cooling memory for shutdown
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cool_seen <= 1'b0;
    else
      cool_seen <= (state == MSP_ST_SHUT) &&
                   (cool_seen || !over_temperature_detector);
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode <= MSP_MODE_RESERVED;
      mode_valid <= 1'b0;
      cpu_clk_en <= 1'b1;
      core_supply_en <= 1'b1;
      lbm_active <= 1'b1;
      retention_ram_active <= 1'b1;
      otd_en <= 1'b0;
      lf_en <= 1'b1;
      always_on_en <= 1'b1;
      reinit_req <= 1'b0;
    end
    else
    begin
      mode <= cap_mode;
      mode_valid <= cap_valid;
      cpu_clk_en <= next_cpu;
      core_supply_en <= next_core;
      lbm_active <= next_keep;
      retention_ram_active <= next_keep;
      otd_en <= next_otd;
      lf_en <= next_lf;
      always_on_en <= 1'b1;
      reinit_req <= next_reinit;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_hot_shut;
    (state == MSP_ST_SHUT) && !cool_seen && over_temperature_detector;
  endsequence
  sequence s_timer_reset;
    wdt_reset;
  endsequence

  property p_reserved_hold;
    is_reserved |-> state == MSP_ST_INIT;
  endproperty
  a_reserved_hold: assert property (p_reserved_hold)
    else $error("Reserved straps left init.");

  property p_normal_only;
    cap_valid && !is_normal |-> state inside {MSP_ST_INIT, MSP_ST_RUN};
  endproperty
  a_normal_only: assert property (p_normal_only)
    else $error("Low power state outside normal mode.");

  property p_reset_init;
    (state != MSP_ST_SHUT) && (wdt_reset || sw_reset) |=> state == MSP_ST_INIT;
  endproperty
  a_reset_init: assert property (p_reset_init)
    else $error("System reset did not reach init.");

  property p_idle_clk;
    state == MSP_ST_IDLE |-> !cpu_clk_en && core_supply_en && retention_ram_active;
  endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("Idle clocking wrong.");

  property p_idle_exit;
    state == MSP_ST_IDLE && irq_pending && !wdt_reset && !sw_reset
      |=> state == MSP_ST_RUN && cpu_clk_en;
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("Interrupt did not end idle.");

  property p_pdown_wait;
    state == MSP_ST_PDOWN && !wake_event && !wdt_reset && !sw_reset
      |=> state == MSP_ST_PDOWN;
  endproperty
  a_pdown_wait: assert property (p_pdown_wait)
    else $error("Power down left without wake.");

  property p_shut_order;
    s_hot_shut ##0 s_timer_reset |=> state == MSP_ST_SHUT;
  endproperty
  a_shut_order: assert property (p_shut_order)
    else $error("Shutdown resumed before cooling.");

  property p_no_supply;
    state inside {MSP_ST_PDOWN, MSP_ST_SHUT} |-> !core_supply_en && !cpu_clk_en
      && !otd_en && always_on_en;
  endproperty
  a_no_supply: assert property (p_no_supply)
    else $error("Core supply on in low power state.");

  property p_hub;
    $changed(state) && state inside {MSP_ST_IDLE, MSP_ST_PDOWN, MSP_ST_SHUT}
      |-> $past(state) == MSP_ST_RUN;
  endproperty
  a_hub: assert property (p_hub)
    else $error("Low power state entered from outside run.");

  property p_reinit;
    state == MSP_ST_INIT && $past(state) == MSP_ST_PDOWN |-> reinit_req;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("Wake from power down without reinit flag.");

endmodule : msp_power_ctrl

`default_nettype wire

// *** msp_power_ctrl_tb.sv ***
// Self-checking bench for the power state controller.
// Assumes the board model for the straps; the bench plays the firmware and event sources.
`timescale 1ns/1ns
`default_nettype none

module msp_power_ctrl_tb;
  import msp_pkg::*;
  localparam int INIT_N = 8;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strap_code = 2'h3;
  logic req_idle = 1'b0, req_pdown = 1'b0, req_shutdown = 1'b0, irq_pending = 1'b0;
  logic wake_event = 1'b0, wdt_reset = 1'b0, sw_reset = 1'b0, over_temperature_detector = 1'b0;
  logic otd_select = 1'b1, lf_pdown_select = 1'b0;
  logic mode_strap_high, mode_strap_low, mode_valid;
  logic cpu_clk_en, core_supply_en, lbm_active, retention_ram_active;
  logic otd_en, lf_en, always_on_en, reinit_req;
  msp_mode_t mode;
  msp_state_t state;
  int err_count = 0;
  int n_tests = 0;
  wire [7:0] pwr;

  // Power outputs packed: cpu, core, lbm, retention, otd, lf, always on, reinit.
  assign pwr = {cpu_clk_en, core_supply_en, lbm_active, retention_ram_active,
    otd_en, lf_en, always_on_en, reinit_req};

  // --------------------------------------------------------------------
  // Clock and instances
  // --------------------------------------------------------------------
  always #25 mclk = ~mclk;

  msp_board_model msp_board_model_inst (.strap_code(strap_code),
    .mode_strap_high(mode_strap_high), .mode_strap_low(mode_strap_low));

  msp_power_ctrl #(.INIT_CYCLES(INIT_N)) msp_power_ctrl_inst (.mclk(mclk), .rst_n(rst_n),
    .mode_strap_high(mode_strap_high), .mode_strap_low(mode_strap_low),
    .req_idle(req_idle), .req_pdown(req_pdown), .req_shutdown(req_shutdown),
    .irq_pending(irq_pending), .wake_event(wake_event), .wdt_reset(wdt_reset),
    .sw_reset(sw_reset), .over_temperature_detector(over_temperature_detector),
    .otd_select(otd_select), .lf_pdown_select(lf_pdown_select), .mode(mode),
    .mode_valid(mode_valid), .state(state), .cpu_clk_en(cpu_clk_en),
    .core_supply_en(core_supply_en), .lbm_active(lbm_active),
    .retention_ram_active(retention_ram_active), .otd_en(otd_en), .lf_en(lf_en),
    .always_on_en(always_on_en), .reinit_req(reinit_req));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  // Inputs move 1 ns after the edge so the design never sees a race.
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A bounded wait; the design's own state is the completion signal.
  task automatic wait_st(input msp_state_t st);
    int i;
    i = 0;
    while (state !== st && i < 4 * INIT_N)
    begin
      step(1);
      i++;
    end
    chk(8'(state), 8'(st));
  endtask : wait_st

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  // Power-on reset with a strap code, then boot through init, or stay in init for the reserved code.
  task automatic t_boot(input logic [1:0] code);
    strap_code = code;
    rst_n = 1'b0;
    step(4);
    chk(8'(state), 8'(MSP_ST_INIT));
    chk(pwr, 8'hf6);
    chk({7'h0, mode_valid}, 8'h00);
    rst_n = 1'b1;
    step(3);
    chk({6'h0, mode}, {6'h0, code});
    chk({7'h0, mode_valid}, 8'h01);
    if (code == 2'h0)
    begin
      step(2 * INIT_N);
      chk(8'(state), 8'(MSP_ST_INIT));
    end
    else
      wait_st(MSP_ST_RUN);
  endtask : t_boot

  // Debug and programming modes boot but refuse an idle request.
  task automatic t_side_modes;
    for (int c = 1; c < 3; c++)
    begin
      t_boot(2'(c));
      req_idle = 1'b1;
      step(2);
      req_idle = 1'b0;
      chk(8'(state), 8'(MSP_ST_RUN));
    end
  endtask : t_side_modes

  // Idle stops only the CPU clock; other requests wait for run; an interrupt resumes.
  task automatic t_idle;
    req_idle = 1'b1;
    step(1);
    req_idle = 1'b0;
    chk(8'(state), 8'(MSP_ST_IDLE));
    chk(pwr, 8'h7e);
    // Firmware may switch the temperature detector off while idle.
    otd_select = 1'b0;
    step(1);
    chk(pwr, 8'h76);
    otd_select = 1'b1;
    req_pdown = 1'b1;
    step(3);
    req_pdown = 1'b0;
    chk(8'(state), 8'(MSP_ST_IDLE));
    irq_pending = 1'b1;
    step(1);
    irq_pending = 1'b0;
    chk(8'(state), 8'(MSP_ST_RUN));
    chk(pwr, 8'hfe);
  endtask : t_idle

  // Power down cuts the core, ignores interrupts, and wakes through init.
  task automatic t_pdown;
    req_pdown = 1'b1;
    step(1);
    req_pdown = 1'b0;
    chk(pwr, 8'h02);
    irq_pending = 1'b1;
    step(3);
    irq_pending = 1'b0;
    chk(8'(state), 8'(MSP_ST_PDOWN));
    wake_event = 1'b1;
    step(1);
    wake_event = 1'b0;
    chk(8'(state), 8'(MSP_ST_INIT));
    chk(pwr, 8'hf7);
    wait_st(MSP_ST_RUN);
    chk(pwr, 8'hfe);
  endtask : t_pdown

  // Shutdown wins over power down and leaves only after cooling then a timer reset.
  task automatic t_shut;
    lf_pdown_select = 1'b1;
    over_temperature_detector = 1'b1;
    req_shutdown = 1'b1;
    req_pdown = 1'b1;
    step(1);
    req_shutdown = 1'b0;
    req_pdown = 1'b0;
    chk(8'(state), 8'(MSP_ST_SHUT));
    chk(pwr, 8'h06);
    wdt_reset = 1'b1;
    step(1);
    wdt_reset = 1'b0;
    sw_reset = 1'b1;
    step(1);
    sw_reset = 1'b0;
    chk(8'(state), 8'(MSP_ST_SHUT));
    over_temperature_detector = 1'b0;
    step(1);
    over_temperature_detector = 1'b1;
    step(1);
    wdt_reset = 1'b1;
    step(1);
    wdt_reset = 1'b0;
    chk(pwr, 8'hf7);
    wait_st(MSP_ST_RUN);
    lf_pdown_select = 1'b0;
    over_temperature_detector = 1'b0;
  endtask : t_shut

  // Software and timer resets restart the device but keep the captured mode.
  task automatic t_keep_mode;
    strap_code = 2'h1;
    sw_reset = 1'b1;
    step(1);
    sw_reset = 1'b0;
    chk(8'(state), 8'(MSP_ST_INIT));
    wait_st(MSP_ST_RUN);
    wdt_reset = 1'b1;
    step(1);
    wdt_reset = 1'b0;
    chk(8'(state), 8'(MSP_ST_INIT));
    wait_st(MSP_ST_RUN);
    chk({6'h0, mode}, 8'h03);
  endtask : t_keep_mode

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial
  begin
    t_boot(2'h3);
    t_idle();
    t_pdown();
    t_shut();
    t_keep_mode();
    t_side_modes();
    t_boot(2'h0);
    final_report();
  end

  // The run needs little more than a hundred cycles; 5000 means something hung.
  initial
  begin
    #(50 * 5000);
    err_count++;
    final_report();
  end
endmodule : msp_power_ctrl_tb

`default_nettype wire
